// ==== hdl/crc_unit.sv ====
/*
 crc unit: byte fifo, register file, crc engine and flash auto-scan.
 assumes the processor holds an access while cpu_stall_o is high and that
 the flash answers each one-cycle request with one valid byte later.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_ni,
	// fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;
	fifo_st_t s_q, s_d;
	logic push, pop;

	// pointers wrap by overflow, so depth must be a power of two
	assign in_ready_o = s_q.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = s_q.cnt != '0;
	assign out_data_o = s_q.mem[s_q.rp];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// next state of storage and counters
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data_i;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

module crc_unit #(
	parameter int FIFO_W = 8,
	parameter int FIFO_D = crc_unit_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// special function register bus
	input wire crc_unit_pkg::sfr_req_t sfr_i,
	output logic [7:0] sfr_rdata_o,
	output logic cpu_stall_o,
	// flash read port
	output crc_unit_pkg::flash_req_t flash_o,
	input wire crc_unit_pkg::flash_rsp_t flash_i
);
	import crc_unit_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DRAIN} auto_st_t;
	typedef struct packed {
		logic [15:0] crc;
		logic sel;
		logic ptr;
		logic [7:0] auto_cfg;
		logic [7:0] blk_cnt;
		logic [7:0] flip;
		logic [7:0] rdata;
		auto_st_t st;
		logic [FLASH_AW-1:0] faddr;
		logic [7:0] left;
	} state_t;

	localparam state_t STATE_RESET = '{
		crc: RESULT_RESET,
		sel: CONTROL_RESET[CTL_SEL_BIT],
		ptr: CONTROL_RESET[CTL_PTR_BIT],
		auto_cfg: REG8_RESET,
		blk_cnt: REG8_RESET,
		flip: REG8_RESET,
		rdata: REG8_RESET,
		st: ST_IDLE,
		faddr: '0,
		left: REG8_RESET
	};

	state_t s_q, s_d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic busy, access, hit_res, wr_take, rd_take;
	logic f_in_valid, f_in_ready, f_out_valid;
	logic [FIFO_W-1:0] f_in_data, f_out_data;
	logic [7:0] flip_in, ctl_rd;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// bus acceptance: result and control wait until queued bytes are folded,
	// so a read never returns a stale result and init never overtakes input
	assign busy = s_q.st != ST_IDLE;
	assign access = sfr_i.wr | sfr_i.rd;
	assign hit_res = (sfr_i.addr == ADDR_RESULT) | (sfr_i.addr == ADDR_CONTROL);
	assign cpu_stall_o = busy
		| (access & (sfr_i.addr == ADDR_INPUT) & ~f_in_ready)
		| (access & hit_res & f_out_valid);
	assign wr_take = sfr_i.wr & ~cpu_stall_o;
	assign rd_take = sfr_i.rd & ~cpu_stall_o & ~sfr_i.wr;

	// fifo source: flash bytes during a scan, processor bytes otherwise
	assign f_in_valid = busy ? ((s_q.st == ST_WAIT) & flash_i.valid)
		: (wr_take & (sfr_i.addr == ADDR_INPUT));
	assign f_in_data = busy ? flash_i.data : sfr_i.wdata;

	byte_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_ni(rst_n),
		.in_valid_i(f_in_valid),
		.in_data_i(f_in_data),
		.in_ready_o(f_in_ready),
		.out_valid_o(f_out_valid),
		.out_data_o(f_out_data),
		.out_ready_i(1'b1)
	);

	// mirrored copy of the written byte, one wire per bit
	for (genvar g = 0; g < 8; g++) begin : g_flip
		assign flip_in[g] = sfr_i.wdata[7-g];
	end

	// control read image: init bit is a trigger and always reads zero
	always_comb begin
		ctl_rd = 8'h00;
		ctl_rd[7:4] = CTL_FIXED_HI;
		ctl_rd[CTL_SEL_BIT] = s_q.sel;
		ctl_rd[CTL_PTR_BIT] = s_q.ptr;
	end

	// flash port from state flops; request also gated by fifo room
	assign flash_o.req = (s_q.st == ST_REQ) & f_in_ready;
	assign flash_o.addr = s_q.faddr;
	assign sfr_rdata_o = s_q.rdata;

	// next state: engine fold, register writes and reads, scan sequencer
	always_comb begin
		s_d = s_q;
		if (f_out_valid) begin
			s_d.crc = crc_byte(s_q.crc, f_out_data);
		end
		if (wr_take) begin
			case (sfr_i.addr)
				ADDR_CONTROL: begin
					s_d.sel = sfr_i.wdata[CTL_SEL_BIT];
					s_d.ptr = sfr_i.wdata[CTL_PTR_BIT];
					if (sfr_i.wdata[CTL_INIT_BIT]) begin
						s_d.crc = sfr_i.wdata[CTL_SEL_BIT] ? PRESET_ONES : PRESET_ZERO;
					end
					// any control write starts an armed scan; zero blocks is a no-op
					if (s_q.auto_cfg[AUTO_EN_BIT] && s_q.blk_cnt != 8'h00) begin
						s_d.st = ST_REQ;
						s_d.faddr = {s_q.auto_cfg[PAGE_W-1:0], 8'h00};
						s_d.left = s_q.blk_cnt;
					end
				end
				ADDR_RESULT: begin
					if (s_q.ptr) begin
						s_d.crc[15:8] = sfr_i.wdata;
					end else begin
						s_d.crc[7:0] = sfr_i.wdata;
					end
					s_d.ptr = ~s_q.ptr;
				end
				ADDR_AUTO_CFG: begin
					s_d.auto_cfg = sfr_i.wdata;
				end
				ADDR_BLOCK_CNT: begin
					s_d.blk_cnt = sfr_i.wdata;
				end
				ADDR_BIT_REV: begin
					s_d.flip = flip_in;
				end
				default: begin
				end
			endcase
		end
		if (rd_take) begin
			case (sfr_i.addr)
				ADDR_CONTROL: begin
					s_d.rdata = ctl_rd;
				end
				ADDR_RESULT: begin
					s_d.rdata = s_q.ptr ? s_q.crc[15:8] : s_q.crc[7:0];
					s_d.ptr = ~s_q.ptr;
				end
				ADDR_AUTO_CFG: begin
					s_d.rdata = s_q.auto_cfg;
				end
				ADDR_BLOCK_CNT: begin
					s_d.rdata = s_q.blk_cnt;
				end
				ADDR_BIT_REV: begin
					s_d.rdata = s_q.flip;
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
		// one flash byte in flight at a time keeps the fifo from overflowing
		case (s_q.st)
			ST_IDLE: begin
			end
			ST_REQ: begin
				if (f_in_ready) begin
					s_d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (flash_i.valid) begin
					s_d.faddr = s_q.faddr + FLASH_AW'(1);
					s_d.st = ST_REQ;
					if (s_q.faddr[7:0] == 8'hFF) begin
						s_d.left = s_q.left - 8'h01;
						if (s_q.left == 8'h01) begin
							s_d.st = ST_DRAIN;
						end
					end
				end
			end
			ST_DRAIN: begin
				// stall holds until the last byte has been folded
				if (!f_out_valid) begin
					s_d.st = ST_IDLE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// checks on the engine, registers and scan sequencer
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	property p_vector;
		f_out_valid && s_q.crc == 16'hFFFF && f_out_data == 8'h63 |=> s_q.crc == 16'hBD35;
	endproperty
	a_vector: assert property (p_vector) else $error("crc of 0x63 wrong");

	property p_init;
		wr_take && sfr_i.addr == ADDR_CONTROL && sfr_i.wdata[CTL_INIT_BIT]
		|=> s_q.crc == ($past(sfr_i.wdata[CTL_SEL_BIT]) ? 16'hFFFF : 16'h0000);
	endproperty
	a_init: assert property (p_init) else $error("preset not loaded");

	property p_ptr;
		(rd_take || wr_take) && sfr_i.addr == ADDR_RESULT |=> s_q.ptr != $past(s_q.ptr);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer did not advance");

	property p_rd_byte;
		rd_take && sfr_i.addr == ADDR_RESULT
		|=> sfr_rdata_o == ($past(s_q.ptr) ? $past(s_q.crc[15:8]) : $past(s_q.crc[7:0]));
	endproperty
	a_rd_byte: assert property (p_rd_byte) else $error("wrong result byte");

	// checked on the stored copy, so any spacing of the later read is covered
	property p_flip;
		wr_take && sfr_i.addr == ADDR_BIT_REV && sfr_i.wdata == 8'hC0 |=> s_q.flip == 8'h03;
	endproperty
	a_flip: assert property (p_flip) else $error("bit reverse wrong");

	property p_ctl_fixed;
		rd_take && sfr_i.addr == ADDR_CONTROL
		|=> sfr_rdata_o[7:4] == 4'h1 && sfr_rdata_o[3] == 1'b0 && sfr_rdata_o[1] == 1'b0;
	endproperty
	a_ctl_fixed: assert property (p_ctl_fixed) else $error("control fixed bits");

	property p_start;
		wr_take && sfr_i.addr == ADDR_CONTROL && s_q.auto_cfg[AUTO_EN_BIT] && s_q.blk_cnt != 8'h00
		|=> cpu_stall_o && s_q.faddr[7:0] == 8'h00 && s_q.st == ST_REQ;
	endproperty
	a_start: assert property (p_start) else $error("scan did not start");

	property p_stall;
		busy |-> cpu_stall_o && !wr_take && !rd_take;
	endproperty
	a_stall: assert property (p_stall) else $error("processor not stalled");

	property p_hold;
		!f_out_valid && !(wr_take && hit_res) |=> $stable(s_q.crc);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed");

	property p_input;
		wr_take && sfr_i.addr == ADDR_INPUT && !f_out_valid
		|=> f_out_valid && f_out_data == $past(sfr_i.wdata)
		##1 s_q.crc == crc_byte($past(s_q.crc), $past(f_out_data));
	endproperty
	a_input: assert property (p_input) else $error("input byte not folded");

	property p_ascend;
		s_q.st == ST_WAIT && flash_i.valid |=> s_q.faddr == FLASH_AW'($past(s_q.faddr) + 1);
	endproperty
	a_ascend: assert property (p_ascend) else $error("flash address skipped");

	c_scan_done: cover property (s_q.st == ST_DRAIN ##1 s_q.st == ST_IDLE);
	c_fifo_full: cover property (!f_in_ready);
	c_read_high: cover property (rd_take && sfr_i.addr == ADDR_RESULT && s_q.ptr);
	c_init_ones: cover property (wr_take && sfr_i.addr == ADDR_CONTROL && sfr_i.wdata == 8'h0C);
endmodule

`default_nettype wire

// ==== hdl/crc_unit_pkg.sv ====
/*
 crc unit package: register addresses, field positions, reset values and
 the structs carried on the register bus and the flash read port.
 assumes an 8-bit special function register bus driven by the processor
 core, and a byte-wide flash read port outside this block.
*/
package crc_unit_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'hDF;
	localparam logic [7:0] ADDR_INPUT = 8'h9C;
	localparam logic [7:0] ADDR_RESULT = 8'h9E;
	localparam logic [7:0] ADDR_AUTO_CFG = 8'h9A;
	localparam logic [7:0] ADDR_BLOCK_CNT = 8'h9B;
	localparam logic [7:0] ADDR_BIT_REV = 8'h9D;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] PRESET_ZERO = 16'h0000;
	localparam logic [15:0] PRESET_ONES = 16'hFFFF;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam int CTL_INIT_BIT = 3;
	localparam int CTL_SEL_BIT = 2;
	localparam int CTL_PTR_BIT = 0;
	localparam logic [3:0] CTL_FIXED_HI = 4'h1;
	localparam logic [7:0] CONTROL_RESET = 8'h10;
	localparam int AUTO_EN_BIT = 7;
	localparam int PAGE_W = 6;
	localparam int FLASH_AW = PAGE_W + 8;
	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam int FIFO_DEPTH = 16;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic req;
		logic [FLASH_AW-1:0] addr;
	} flash_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} flash_rsp_t;

	// one whole byte of the polynomial division per call
	function automatic logic [15:0] crc_byte(input logic [15:0] acc, input logic [7:0] b);
		logic [15:0] c;
		c = acc ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// ==== sim/flash_model.sv ====
/*
 flash model: answers each one-cycle read request with one valid byte
 after LAT cycles; the byte is a fixed function of its address.
 assumes one request outstanding at a time, as the crc unit keeps.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_model #(
	parameter int LAT = 2
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// read port
	input wire crc_unit_pkg::flash_req_t req_i,
	output crc_unit_pkg::flash_rsp_t rsp_o
);
	import crc_unit_pkg::*;
	logic [FLASH_AW-1:0] addr_q;
	logic busy_q;
	logic [7:0] last_q;
	int cnt_q;
	wire logic [7:0] byte_w = addr_q[7:0] ^ {addr_q[13:8], 2'b01};

	// released data lines show the inverse so stale bytes never pass
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_q <= 1'b0;
			rsp_o <= '0;
			last_q <= 8'h00;
			cnt_q <= 0;
		end else begin
			rsp_o.valid <= 1'b0;
			rsp_o.data <= ~last_q;
			if (req_i.req && !busy_q) begin
				busy_q <= 1'b1;
				addr_q <= req_i.addr;
				cnt_q <= LAT - 1;
			end else if (busy_q && cnt_q != 0) begin
				cnt_q <= cnt_q - 1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				rsp_o.valid <= 1'b1;
				rsp_o.data <= byte_w;
				last_q <= byte_w;
			end
		end
	end
endmodule

`default_nettype wire

// ==== sim/crc_unit_tb_top.sv ====
/*
 testbench for the crc unit: reset, then table rows, register, overwrite,
 bit reverse and flash scan cases. assumes the flash model alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module crc_unit_tb_top;
	import crc_unit_pkg::*;
	typedef struct packed {
		logic [2:0] n;
		logic [39:0] data;
		logic [15:0] exp;
	} row_t;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	sfr_req_t sfr_i = '0;
	logic [7:0] sfr_rdata_o;
	logic cpu_stall_o;
	flash_req_t flash_o;
	flash_rsp_t flash_i;
	int fails = 0;
	int samples_checked = 0;
	int stall_cycles = 0;
	logic [13:0] next_addr = 14'h0300;
	logic [13:0] fa;
	logic [7:0] q;
	logic [15:0] e;
	row_t rows[5];

	crc_unit dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sfr_i(sfr_i),
		.sfr_rdata_o(sfr_rdata_o), .cpu_stall_o(cpu_stall_o), .flash_o(flash_o),
		.flash_i(flash_i));
	flash_model #(.LAT(2)) flash_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.req_i(flash_o), .rsp_o(flash_i));

	always #20 sys_clk_i = ~sys_clk_i;

	// own reference, kept apart from the design's function
	function automatic logic [15:0] ref_crc(logic [15:0] a, logic [7:0] b);
		a = a ^ {b, 8'h00};
		repeat (8) a = {a[14:0], 1'b0} ^ (a[15] ? 16'h1021 : 16'h0000);
		return a;
	endfunction

	// mirrored byte, bit k takes bit 7-k
	function automatic logic [7:0] rev8(logic [7:0] b);
		logic [7:0] m;
		for (int k = 0; k < 8; k++) m[k] = b[7 - k];
		return m;
	endfunction

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until an edge where stall is low; one idle cycle after
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d, output logic [7:0] r);
		logic ok;
		int n;
		n = 0;
		@(posedge sys_clk_i);
		#1;
		sfr_i = '{wr: w, rd: !w, addr: a, wdata: d};
		do begin
			@(negedge sys_clk_i);
			ok = !cpu_stall_o;
			@(posedge sys_clk_i);
			n++;
		end while (!ok && n < 20000);
		if (!ok) fails++;
		#1;
		sfr_i = '0;
		r = sfr_rdata_o;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd_res(string what, logic [15:0] exp);
		logic [7:0] lo;
		logic [7:0] hi;
		bus(1'b0, ADDR_RESULT, 8'h00, lo);
		bus(1'b0, ADDR_RESULT, 8'h00, hi);
		check(what, exp, {hi, lo});
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// scan traffic: stall length and ascending flash addresses
	always @(posedge sys_clk_i) begin
		if (cpu_stall_o) stall_cycles++;
		if (flash_o.req) begin
			check("flash addr", {2'b00, next_addr}, {2'b00, flash_o.addr});
			next_addr++;
		end
	end

	initial begin
		#(40 * 30000);
		fails++;
		print_verdict();
	end

	initial begin
		rows[0] = '{1, 40'h6300000000, 16'hBD35};
		rows[1] = '{1, 40'h8C00000000, 16'hB1F4};
		rows[2] = '{1, 40'h7D00000000, 16'h4ECA};
		rows[3] = '{3, 40'hAABBCC0000, 16'h6CF6};
		rows[4] = '{5, 40'h0000AABBCC, 16'hB166};
		repeat (12) @(posedge sys_clk_i);
		check("stall in reset", 16'h0000, {15'h0, cpu_stall_o});
		check("rdata in reset", 16'h0000, {8'h00, sfr_rdata_o});
		#1;
		reset_n_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		bus(1'b0, ADDR_CONTROL, 8'h00, q);
		check("control reset", 16'h0010, {8'h00, q});
		rd_res("result reset", 16'h0000);
		// table rows from preset ones, read straight after the last byte
		foreach (rows[i]) begin
			wr(ADDR_CONTROL, 8'h0C);
			for (int k = 0; k < rows[i].n; k++) wr(ADDR_INPUT, rows[i].data[39 - 8 * k -: 8]);
			rd_res("table vector", rows[i].exp);
		end
		// upper nibble fixed, init and bit1 read zero, pointer set to 1
		wr(ADDR_CONTROL, 8'hEF);
		bus(1'b0, ADDR_CONTROL, 8'h00, q);
		check("control fields", 16'h0015, {8'h00, q});
		bus(1'b0, ADDR_RESULT, 8'h00, q);
		check("pointer one byte", 16'h00FF, {8'h00, q});
		// preset zero then one byte, read back to back
		wr(ADDR_CONTROL, 8'h08);
		wr(ADDR_INPUT, 8'h63);
		rd_res("zero preset", ref_crc(16'h0000, 8'h63));
		// overwrite through the access port, then hold, then fold
		wr(ADDR_RESULT, 8'h34);
		wr(ADDR_RESULT, 8'h12);
		repeat (20) @(posedge sys_clk_i);
		rd_res("overwrite hold", 16'h1234);
		wr(ADDR_INPUT, 8'hA5);
		rd_res("fold after write", ref_crc(16'h1234, 8'hA5));
		foreach (rows[i]) begin
			wr(ADDR_BIT_REV, rows[i].data[39:32] | 8'hC0);
			bus(1'b0, ADDR_BIT_REV, 8'h00, q);
			check("bit reverse", {8'h00, rev8(rows[i].data[39:32] | 8'hC0)}, {8'h00, q});
		end
		bus(1'b0, 8'h80, 8'h00, q);
		check("unmapped read", 16'h0000, {8'h00, q});
		bus(1'b0, ADDR_INPUT, 8'h00, q);
		check("input reads zero", 16'h0000, {8'h00, q});
		// two flash blocks from page 3, started by a plain control write
		wr(ADDR_CONTROL, 8'h0C);
		wr(ADDR_AUTO_CFG, 8'h83);
		wr(ADDR_BLOCK_CNT, 8'h02);
		stall_cycles = 0;
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_AUTO_CFG, 8'h00);
		check("stall length", 16'h0001, {15'h0, stall_cycles > 512});
		e = 16'hFFFF;
		// expected bytes follow the model's address pattern, kept apart from the monitor
		for (int i = 0; i < 512; i++) begin
			fa = 14'h0300 + i[13:0];
			e = ref_crc(e, fa[7:0] ^ {fa[13:8], 2'b01});
		end
		rd_res("flash scan", e);
		check("scan byte count", 16'h0500, {2'b00, next_addr});
		wr(ADDR_CONTROL, 8'h00);
		check("no restart", 16'h0000, {15'h0, cpu_stall_o});
		print_verdict();
	end
endmodule

`default_nettype wire
